//--- common/rh_power_defs.svh
`ifndef RH_POWER_DEFS_SVH
`define RH_POWER_DEFS_SVH

// ==========================================================================
// Register offsets (byte addresses on the register bus)
`define RH_DESC_B_OFS   8'h4C
`define RH_STATUS_OFS   8'h50
`define RH_PORT1_OFS    8'h54
`define RH_PORT2_OFS    8'h58
`define RH_PORT3_OFS    8'h5C
`define RH_MODE_OFS     8'h60

// ==========================================================================
// Field positions
`define RH_DR_LSB       0
`define RH_POWER_COMMAND_MASK_LSB     16
`define RH_CGP_BIT      0
`define RH_OCI_BIT      1
`define RH_REMOTE_WAKEUP_ENABLE_BIT     15
`define RH_WAKEUP_ENABLE_SET_CMD_BIT     15
`define RH_SGP_BIT      16
`define RH_GLOBAL_OVERCURRENT_CHANGE_BIT     17
`define RH_WAKEUP_ENABLE_CLEAR_CMD_BIT     31
`define RH_PSM_BIT      0
`define RH_OVERCURRENT_REPORT_MODE_BIT     1
`define RH_PPS_BIT      8

// ==========================================================================
// Reset values and fixed patterns
`define RH_DR_RESET     3'h0
`define RH_PSM_RESET    1'b1
`define RH_OVERCURRENT_REPORT_MODE_RESET   1'b1
`define RH_REMOTE_WAKEUP_ENABLE_RESET   1'b0
`define RH_PORT_INVALID 32'h0FFFFFFF

// ==========================================================================
// Port-count settings
`define RH_CNT_FIVE     3'h5
`define RH_CNT_FOUR     3'h4
`define RH_CNT_THREE    3'h3

`endif

//--- common/rh_power_pkg.sv
package rh_power_pkg;

	// ======================================================================
	// Types
	typedef logic [2:0]  port_vec_type;
	typedef logic [31:0] word_type;
	typedef logic [7:0]  addr_type;

endpackage : rh_power_pkg

//--- src/root_hub_power_status_regs.sv
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "rh_power_defs.svh"

module root_hub_power_status_regs (
	input  wire logic                       ref_clk,
	input  wire logic                       rstn,
	input  wire logic                       softReset,
	input  wire logic                       secondController,
	input  wire logic [2:0]                 portCountConfig,
	input  wire logic                       overcurrentPin,
	input  wire logic                       cyc_i,
	input  wire logic                       stb_i,
	input  wire logic                       we_i,
	input  wire rh_power_pkg::addr_type     adr_i,
	input  wire logic [3:0]                 sel_i,
	input  wire rh_power_pkg::word_type     dat_i,
	output rh_power_pkg::word_type          dat_o,
	output logic                            ack_o,
	output rh_power_pkg::port_vec_type      portPower,
	output logic                            remoteWakeupEnable,
	output logic                            globalOvercurrent
);

	// ======================================================================
	// Helpers

	function automatic rh_power_pkg::port_vec_type valid_ports(
		input logic       second,
		input logic [2:0] cnt
	);
		valid_ports = 3'h1;
		if (!second) begin
			if (cnt == `RH_CNT_FIVE) begin
				valid_ports = 3'h7;
			end else if (cnt == `RH_CNT_FOUR || cnt == `RH_CNT_THREE) begin
				valid_ports = 3'h3;
			end
		end else if (cnt == `RH_CNT_FIVE || cnt == `RH_CNT_FOUR) begin
			valid_ports = 3'h3;
		end
	endfunction : valid_ports

	// ======================================================================
	// Declarations

	rh_power_pkg::port_vec_type validPorts;
	rh_power_pkg::port_vec_type next_validPorts;
	rh_power_pkg::port_vec_type removable_device_bits;
	rh_power_pkg::port_vec_type next_removable_device_bits;
	rh_power_pkg::port_vec_type power_command_mask;
	rh_power_pkg::port_vec_type next_power_command_mask;
	logic                       power_switch_mode;
	logic                       next_power_switch_mode;
	logic                       overcurrent_report_mode;
	logic                       next_overcurrent_report_mode;
	rh_power_pkg::port_vec_type next_portPower;
	logic                       next_remoteWakeupEnable;
	logic                       next_globalOvercurrent;
	logic                       global_overcurrent_change;
	logic                       next_global_overcurrent_change;
	logic                       ocMeta;
	logic                       ocSync;
	rh_power_pkg::word_type     next_dat_o;
	logic                       next_ack_o;
	rh_power_pkg::word_type     readData;
	rh_power_pkg::word_type     writeData;
	logic                       request;
	logic                       writeHit;

	// ======================================================================
	// Bus decode

	// A request is answered one cycle after it is seen; writes and read
	// data both take effect on the edge that raises ack.
	assign request   = cyc_i & stb_i & ~ack_o;
	assign writeHit  = request & we_i;
	assign writeData = dat_i & {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

	always_comb begin
		readData = 32'h00000000;
		case (adr_i)
			`RH_DESC_B_OFS: begin
				readData[`RH_DR_LSB+1 +: 3]   = removable_device_bits;
				readData[`RH_POWER_COMMAND_MASK_LSB+1 +: 3] = power_command_mask;
			end
			`RH_STATUS_OFS: begin
				// Local power bits and the wakeup-clear command bit stay zero here; bit 15 reads the wakeup enable.
				readData[`RH_OCI_BIT]  = globalOvercurrent;
				readData[`RH_REMOTE_WAKEUP_ENABLE_BIT] = remoteWakeupEnable;
				readData[`RH_GLOBAL_OVERCURRENT_CHANGE_BIT] = global_overcurrent_change;
			end
			`RH_PORT1_OFS: begin
				readData[`RH_PPS_BIT] = portPower[0];
			end
			`RH_PORT2_OFS: begin
				if (validPorts[1]) begin
					readData[`RH_PPS_BIT] = portPower[1];
				end else begin
					readData = `RH_PORT_INVALID;
				end
			end
			`RH_PORT3_OFS: begin
				if (validPorts[2]) begin
					readData[`RH_PPS_BIT] = portPower[2];
				end else begin
					readData = `RH_PORT_INVALID;
				end
			end
			`RH_MODE_OFS: begin
				readData[`RH_PSM_BIT]  = power_switch_mode;
				readData[`RH_OVERCURRENT_REPORT_MODE_BIT] = overcurrent_report_mode;
			end
			default: begin
				readData = 32'h00000000;
			end
		endcase
	end

	always_comb begin
		next_ack_o = request;
		next_dat_o = dat_o;
		if (request && !we_i) begin
			next_dat_o = readData;
		end
		if (!rstn) begin
			next_ack_o = 1'b0;
			next_dat_o = 32'h00000000;
		end
	end

	always_ff @(posedge ref_clk) begin
		ack_o <= next_ack_o;
		dat_o <= next_dat_o;
	end

	// ======================================================================
	// Configuration: touched only by hardware reset and software writes

	// Defaults are taken from the port-count setting while reset is held;
	// a later change of the setting needs another hardware reset.
	always_comb begin
		next_validPorts              = validPorts;
		next_removable_device_bits   = removable_device_bits;
		next_power_command_mask      = power_command_mask;
		next_power_switch_mode       = power_switch_mode;
		next_overcurrent_report_mode = overcurrent_report_mode;
		if (writeHit && adr_i == `RH_DESC_B_OFS) begin
			next_removable_device_bits = writeData[`RH_DR_LSB+1 +: 3] & validPorts;
			next_power_command_mask = writeData[`RH_POWER_COMMAND_MASK_LSB+1 +: 3] & validPorts;
		end
		if (writeHit && adr_i == `RH_MODE_OFS) begin
			next_power_switch_mode       = writeData[`RH_PSM_BIT];
			next_overcurrent_report_mode = writeData[`RH_OVERCURRENT_REPORT_MODE_BIT];
		end
		if (!rstn) begin
			next_validPorts = valid_ports(secondController, portCountConfig);
			next_removable_device_bits   = `RH_DR_RESET;
			next_power_command_mask = valid_ports(secondController, portCountConfig);
			next_power_switch_mode       = `RH_PSM_RESET;
			next_overcurrent_report_mode = `RH_OVERCURRENT_REPORT_MODE_RESET;
		end
	end

	always_ff @(posedge ref_clk) begin
		validPorts              <= next_validPorts;
		removable_device_bits   <= next_removable_device_bits;
		power_command_mask      <= next_power_command_mask;
		power_switch_mode       <= next_power_switch_mode;
		overcurrent_report_mode <= next_overcurrent_report_mode;
	end

	// ======================================================================
	// Overcurrent input synchroniser

	always_ff @(posedge ref_clk) begin
		ocMeta <= overcurrentPin;
		ocSync <= ocMeta;
	end

	// ======================================================================
	// Root hub status and port power

	always_comb begin
		rh_power_pkg::port_vec_type target;
		target = 3'h0;
		next_portPower                 = portPower;
		next_remoteWakeupEnable        = remoteWakeupEnable;
		next_global_overcurrent_change = global_overcurrent_change;
		// Per-port mode spares masked ports; global mode drives them all.
		if (power_switch_mode) begin
			target = validPorts & ~power_command_mask;
		end else begin
			target = validPorts;
		end
		next_globalOvercurrent = ocSync & ~overcurrent_report_mode;
		if (writeHit && adr_i == `RH_STATUS_OFS) begin
			if (writeData[`RH_CGP_BIT]) begin
				next_portPower = next_portPower & ~target;
			end
			if (writeData[`RH_SGP_BIT]) begin
				next_portPower = next_portPower | target;
			end
			if (writeData[`RH_WAKEUP_ENABLE_SET_CMD_BIT]) begin
				next_remoteWakeupEnable = 1'b1;
			end
			if (writeData[`RH_WAKEUP_ENABLE_CLEAR_CMD_BIT]) begin
				next_remoteWakeupEnable = 1'b0;
			end
			if (writeData[`RH_GLOBAL_OVERCURRENT_CHANGE_BIT]) begin
				next_global_overcurrent_change = 1'b0;
			end
		end
		// A change in the same cycle as a clear still leaves the flag set.
		if (next_globalOvercurrent != globalOvercurrent) begin
			next_global_overcurrent_change = 1'b1;
		end
		if (softReset) begin
			next_remoteWakeupEnable = `RH_REMOTE_WAKEUP_ENABLE_RESET;
		end
		if (!rstn) begin
			next_portPower                 = 3'h0;
			next_remoteWakeupEnable        = `RH_REMOTE_WAKEUP_ENABLE_RESET;
			next_globalOvercurrent         = 1'b0;
			next_global_overcurrent_change = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		portPower                 <= next_portPower;
		remoteWakeupEnable        <= next_remoteWakeupEnable;
		globalOvercurrent         <= next_globalOvercurrent;
		global_overcurrent_change <= next_global_overcurrent_change;
	end

endmodule : root_hub_power_status_regs

//--- tb/rh_power_assertions.sv
`timescale 1ns/1ps
// ==========================================================================
// Port-level checker for the root hub status bank
module rh_power_checker (
	input wire logic                         ref_clk,
	input wire logic                         rstn,
	input wire logic                         softReset,
	input wire logic                         overcurrentPin,
	input wire logic                         cyc_i,
	input wire logic                         stb_i,
	input wire logic                         we_i,
	input wire rh_power_pkg::addr_type       adr_i,
	input wire logic [3:0]                   sel_i,
	input wire rh_power_pkg::word_type       dat_i,
	input wire rh_power_pkg::word_type       dat_o,
	input wire logic                         ack_o,
	input wire rh_power_pkg::port_vec_type   portPower,
	input wire logic                         remoteWakeupEnable,
	input wire logic                         globalOvercurrent
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	logic take;
	logic stWr;
	assign take = cyc_i && stb_i && !ack_o;
	assign stWr = take && we_i && adr_i == 8'h50;
	a_ack_on_take: assert property (take |=> ack_o) else $error("ack missing after request");
	a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack held too long");
	a_wake_set: assert property (stWr && sel_i[1] && dat_i[15] && !(sel_i[3] && dat_i[31])
		&& !softReset |=> remoteWakeupEnable) else $error("wakeup enable not set");
	a_wake_clear: assert property (stWr && sel_i[3] && dat_i[31] |=> !remoteWakeupEnable)
		else $error("wakeup enable not cleared");
	a_soft_clear: assert property (softReset |=> !remoteWakeupEnable)
		else $error("soft reset kept wakeup enable");
	a_off_no_rise: assert property (stWr && sel_i[0] && dat_i[0] && !(sel_i[2] && dat_i[16])
		|=> (portPower & ~$past(portPower)) == 3'h0) else $error("power off raised a port");
	a_on_no_fall: assert property (stWr && sel_i[2] && dat_i[16]
		|=> ($past(portPower) & ~portPower) == 3'h0) else $error("power on dropped a port");
	a_status_bits: assert property (ack_o && !we_i && adr_i == 8'h50 |-> (dat_o & 32'hFFFD7FFD)
		== 32'h0 && dat_o[15] == $past(remoteWakeupEnable)) else $error("status read wrong");
	a_oc_follows: assert property ($rose(globalOvercurrent) |-> $past(overcurrentPin, 3))
		else $error("overcurrent flag without cause");
endmodule : rh_power_checker

bind root_hub_power_status_regs rh_power_checker rh_power_checker_inst (
	.ref_clk(ref_clk), .rstn(rstn), .softReset(softReset), .overcurrentPin(overcurrentPin),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
	.dat_o(dat_o), .ack_o(ack_o), .portPower(portPower),
	.remoteWakeupEnable(remoteWakeupEnable), .globalOvercurrent(globalOvercurrent));

//--- tb/tb_top.sv
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench for the root hub status bank
module tb_top;
	logic                         ref_clk;
	logic                         rstn;
	logic                         softReset;
	logic                         secondController;
	logic [2:0]                   portCountConfig;
	logic                         overcurrentPin;
	logic                         cyc;
	logic                         stb;
	logic                         we;
	rh_power_pkg::addr_type       adr;
	rh_power_pkg::word_type       dat;
	rh_power_pkg::word_type       rdat;
	logic                         ack;
	rh_power_pkg::port_vec_type   portPower;
	logic                         rwe;
	logic                         gOc;
	int                           errTotal;
	int                           nChecks;
	int                           validTab [8] = '{1, 1, 2, 2, 1, 2, 2, 3};

	root_hub_power_status_regs root_hub_power_status_regs_inst (
		.ref_clk(ref_clk), .rstn(rstn), .softReset(softReset),
		.secondController(secondController), .portCountConfig(portCountConfig),
		.overcurrentPin(overcurrentPin), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(4'hF), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .portPower(portPower),
		.remoteWakeupEnable(rwe), .globalOvercurrent(gOc));

	// ======================================================================
	// Bus and check tasks
	task automatic chk(input string what, input rh_power_pkg::word_type seen,
		input rh_power_pkg::word_type exp);
		nChecks++;
		if (seen !== exp) begin
			errTotal++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// The leading edge leaves one idle cycle between requests; the slave masks request with ack_o and needs none.
	task automatic bus(input rh_power_pkg::addr_type a, input logic w,
		input rh_power_pkg::word_type d);
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge ref_clk); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : bus

	task automatic rd(input rh_power_pkg::addr_type a, input string what,
		input rh_power_pkg::word_type exp);
		bus(a, 1'b0, 32'h0);
		chk(what, rdat, exp);
	endtask : rd

	task automatic softPulse;
		@(posedge ref_clk);
		softReset <= 1'b1;
		@(posedge ref_clk);
		softReset <= 1'b0;
		// The clearing edge has just passed; let its result settle before any compare.
		@(posedge ref_clk);
	endtask : softPulse

	task automatic waitCycles(input logic pin);
		@(posedge ref_clk);
		overcurrentPin <= pin;
		repeat (5) @(posedge ref_clk);
	endtask : waitCycles

	task automatic closeOut;
		$display("checks %0d mismatches %0d", nChecks, errTotal);
		if (errTotal == 0 && nChecks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : closeOut

	// ======================================================================
	// Clock, watchdog and test sequence
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	initial begin
		repeat (5000) @(posedge ref_clk);
		errTotal++;
		closeOut();
	end

	initial begin
		rstn = 1'b0;
		softReset = 1'b0;
		overcurrentPin = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		dat = 32'h0;
		errTotal = 0;
		nChecks = 0;
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk);
			rstn <= 1'b0;
			secondController <= (i < 4);
			portCountConfig <= 3'(2 + i % 4);
			repeat (5) @(posedge ref_clk);
			rstn <= 1'b1;
			rd(8'h4C, "mask default", 32'(((1 << validTab[i]) - 1) << 17));
			rd(8'h58, "port2 status", validTab[i] < 2 ? 32'h0FFFFFFF : 32'h0);
			rd(8'h5C, "port3 status", validTab[i] < 3 ? 32'h0FFFFFFF : 32'h0);
		end
		bus(8'h60, 1'b1, 32'h0);
		bus(8'h50, 1'b1, 32'h00010000);
		chk("global on", 32'(portPower), 32'h7);
		softPulse();
		rd(8'h60, "modes kept", 32'h0);
		rd(8'h4C, "mask kept", 32'h000E0000);
		bus(8'h50, 1'b1, 32'h0);
		chk("zero write", 32'(portPower), 32'h7);
		bus(8'h50, 1'b1, 32'h1);
		chk("global off", 32'(portPower), 32'h0);
		bus(8'h60, 1'b1, 32'h1);
		bus(8'h4C, 1'b1, 32'h000A0000);
		bus(8'h50, 1'b1, 32'h00010000);
		chk("masked on", 32'(portPower), 32'h2);
		rd(8'h58, "port2 power", 32'h00000100);
		bus(8'h4C, 1'b1, 32'hFFF4FFF1);
		rd(8'h4C, "reserved zero", 32'h00040000);
		bus(8'h50, 1'b1, 32'h00010000);
		bus(8'h50, 1'b1, 32'h1);
		chk("masked off", 32'(portPower), 32'h2);
		bus(8'h70, 1'b1, 32'hFFFFFFFF);
		rd(8'h70, "unmapped", 32'h0);
		bus(8'h50, 1'b1, 32'h00008000);
		rd(8'h50, "wake read", 32'h00008000);
		bus(8'h50, 1'b1, 32'h0);
		chk("wake zero write", 32'(rwe), 32'h1);
		bus(8'h50, 1'b1, 32'h80000000);
		chk("wake clear", 32'(rwe), 32'h0);
		bus(8'h50, 1'b1, 32'h00008000);
		softPulse();
		chk("wake soft reset", 32'(rwe), 32'h0);
		waitCycles(1'b1);
		chk("oc flag", 32'(gOc), 32'h1);
		bus(8'h50, 1'b1, 32'h0);
		rd(8'h50, "oc status", 32'h00020002);
		bus(8'h50, 1'b1, 32'h00020000);
		rd(8'h50, "oc change clear", 32'h2);
		waitCycles(1'b0);
		rd(8'h50, "oc released", 32'h00020000);
		bus(8'h50, 1'b1, 32'h00020000);
		bus(8'h60, 1'b1, 32'h3);
		waitCycles(1'b1);
		chk("per port oc", 32'(gOc), 32'h0);
		rd(8'h50, "per port status", 32'h0);
		closeOut();
	end
endmodule : tb_top
